// ### sds_pkg.sv
package sds_pkg;
  // ==========================================================================
  // Sizes
  localparam int NCLS = 8;
  localparam int NGRP = 16;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_WGT_LO = 12'h008;
  localparam logic [11:0] ADDR_WGT_HI = 12'h00C;
  localparam logic [11:0] ADDR_PRIO_MAP = 12'h010;
  localparam logic [11:0] ADDR_PFC = 12'h014;
  localparam logic [5:0] PG_REGION = 6'h01;
  // ==========================================================================
  // Fields
  localparam int CTRL_NSP_LSB = 0;
  localparam int CTRL_DCB_BIT = 4;
  localparam int CTRL_CHA_BIT = 5;
  localparam int STAT_CLS_LSB = 0;
  localparam int STAT_MC_BIT = 3;
  localparam int STAT_ACT_BIT = 4;
  localparam int STAT_ERR_BIT = 8;
  localparam int PG_PFC_BIT = 8;
  // ==========================================================================
  // Reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [63:0] WGT_RST = 64'h0101010101010101;
  localparam logic [31:0] PRIO_MAP_RST = 32'hFEDCBA98;
  localparam logic [15:0] PG_PFC_RST = 16'h0201;
  localparam logic [7:0] PG_BW_RST = 8'h00;
  localparam logic [3:0] NSP_MAX = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // Scheduler states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADV = 3'b010,
    ST_BUSY = 3'b100
  } sds_state_t;
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] sds_strb(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : sds_strb

  // Highest rank wins; equal rank goes to the higher class index
  function automatic logic [3:0] sds_pick_sp(input logic [7:0] cand, input logic [31:0] rk);
    logic [3:0] best;
    logic [2:0] idx;
    logic hit;
    best = 4'h0;
    idx = 3'h0;
    hit = 1'b0;
    for (int c = 0; c < NCLS; c++) begin
      if (cand[c] && (!hit || rk[4*c +: 4] >= best)) begin
        hit = 1'b1;
        best = rk[4*c +: 4];
        idx = 3'(c);
      end
    end
    return {hit, idx};
  endfunction : sds_pick_sp

  // Next lower candidate below ptr, wrapping from 0 back to 7
  function automatic logic [2:0] sds_next_rr(input logic [7:0] cand, input logic [2:0] ptr);
    logic [2:0] nx;
    logic [2:0] k3;
    nx = ptr;
    for (int k = NCLS; k >= 1; k--) begin
      k3 = 3'(k);
      if (cand[ptr - k3]) begin
        nx = ptr - k3;
      end
    end
    return nx;
  endfunction : sds_next_rr
endpackage : sds_pkg

// ### sds_scheduler.sv
// Contract
// - Eight classes 0..7; higher index means higher priority.
// - Strict queue keeps sending until empty before lower classes are served.
// - Strict count configurable 0..8; top classes strict, rest weighted rotation.
// - With N strict levels class 7 is level N, class 6 level N-1, downward.
// - Strict queues first; rotation only over non-empty queues when strict ones empty.
// - Each rotation queue has a weight; bandwidth shared in proportion.
// - Rotation visits queues in fixed order, wrapping from lowest to highest.
// - Overrun is carried as deficit and subtracted in later rounds.
// - Several physical queues of one class are equal-priority candidates.
// - Multicast class inherits scheduling of the unicast class with same index.
// - Sixteen group entries: policy, weight, relative priority, PFC enable.
// - Groups 15.x are strict; groups 0..7 use deficit weighted rotation.
// - Group priority follows table order, 15.0 highest, group 7 lowest.
// - Reset table: PFC only on 15.0 and 1, zero bandwidth everywhere.
// - Priority table maps each CoS to a group; PFC comes from that group.
// - At most one CoS per PFC group; CoS maps to equal traffic class.
// - Violating mapping flags error and restores the whole group table.
// - Facing a converged host adapter only one strict group is allowed.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module sds_scheduler
  import sds_pkg::*;
#(
  parameter int LEN_W = 14,
  parameter int DEF_W = 24,
  parameter int QUANTUM_SHIFT = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] uc_queue_nempty,
  input wire logic [7:0] mc_queue_nempty,
  input wire logic tx_frame_done,
  input wire logic [LEN_W-1:0] tx_frame_bytes,
  output logic grant_valid,
  output logic [2:0] grant_class,
  output logic grant_mc,
  output logic [7:0] class_pfc_en,
  output logic map_error
);
  // ==========================================================================
  // Register bus
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [5:0] ctrl_q;
  logic [63:0] wgt_q;
  logic [31:0] prio_map_q;
  logic [7:0] pg_bw_q [NGRP];
  logic [15:0] pg_pfc_q;
  logic err_q, chk_q, viol;
  logic [7:0] pfc_en_q;
  logic [31:0] rd_data;
  logic rd_hit;

  wire wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  wire in_pg = awaddr_q[11:6] == PG_REGION;
  wire [3:0] wr_grp = awaddr_q[5:2];
  wire wr_ctrl = wr_fire && awaddr_q == ADDR_CTRL;
  wire wr_stat = wr_fire && awaddr_q == ADDR_STAT;
  wire wr_wlo = wr_fire && awaddr_q == ADDR_WGT_LO;
  wire wr_whi = wr_fire && awaddr_q == ADDR_WGT_HI;
  wire wr_map = wr_fire && awaddr_q == ADDR_PRIO_MAP;
  wire wr_pg = wr_fire && in_pg;
  wire wr_hit = wr_ctrl || wr_stat || wr_wlo || wr_whi || wr_map || wr_pg;
  wire [31:0] pg_cur = {23'h0, pg_pfc_q[wr_grp], pg_bw_q[wr_grp]};
  wire [31:0] pg_new = sds_strb(pg_cur, wdata_q, wstrb_q);
  wire [31:0] ctrl_new = sds_strb({26'h0, ctrl_q}, wdata_q, wstrb_q);
  wire restore = chk_q && viol;
  // Error flag: set on a bad mapping, cleared by writing one; set wins
  wire err_clr = wr_stat && wstrb_q[1] && wdata_q[STAT_ERR_BIT];

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Configuration storage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
      wgt_q <= WGT_RST;
      prio_map_q <= PRIO_MAP_RST;
      err_q <= 1'b0;
      chk_q <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_new[5:0];
      if (wr_wlo) wgt_q[31:0] <= sds_strb(wgt_q[31:0], wdata_q, wstrb_q);
      if (wr_whi) wgt_q[63:32] <= sds_strb(wgt_q[63:32], wdata_q, wstrb_q);
      if (wr_map) prio_map_q <= sds_strb(prio_map_q, wdata_q, wstrb_q);
      chk_q <= wr_map || wr_pg || wr_ctrl;
      err_q <= restore || (err_q && !err_clr);
    end
  end

  // Reset contents double as the restore image after a bad mapping
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pg_pfc_q <= PG_PFC_RST;
      for (int g = 0; g < NGRP; g++) pg_bw_q[g] <= PG_BW_RST;
    end else if (restore) begin
      pg_pfc_q <= PG_PFC_RST;
      for (int g = 0; g < NGRP; g++) pg_bw_q[g] <= PG_BW_RST;
    end else if (wr_pg) begin
      pg_pfc_q[wr_grp] <= pg_new[PG_PFC_BIT];
      pg_bw_q[wr_grp] <= pg_new[7:0];
    end
  end

  // ==========================================================================
  // Per-class scheduling view
  logic [3:0] cls_grp [NCLS];
  logic [7:0] cls_wgt [NCLS];
  logic [31:0] cls_rank;
  logic [7:0] is_sp;
  wire dcb_mode = ctrl_q[CTRL_DCB_BIT];
  wire cha_mode = ctrl_q[CTRL_CHA_BIT];
  wire [3:0] nsp_raw = ctrl_q[CTRL_NSP_LSB +: 4];
  wire [3:0] nsp = nsp_raw > NSP_MAX ? NSP_MAX : nsp_raw;

  for (genvar c = 0; c < NCLS; c++) begin : g_cls
    // Group index 0..7 is 15.0..15.7, 8..15 is group 0..7
    assign cls_grp[c] = prio_map_q[4*c +: 4];
    assign is_sp[c] = dcb_mode ? !cls_grp[c][3]
                    : ({1'b0, 4'(c)} + {1'b0, nsp}) >= {1'b0, NSP_MAX};
    assign cls_rank[4*c +: 4] = dcb_mode ? 4'hF - cls_grp[c] : 4'(c);
    assign cls_wgt[c] = dcb_mode ? pg_bw_q[cls_grp[c]] : wgt_q[8*c +: 8];
  end

  // Mapping check: one CoS per PFC group, one strict group for an adapter
  always_comb begin
    logic [3:0] cnt;
    logic [15:0] sp_used;
    viol = 1'b0;
    cnt = 4'h0;
    sp_used = 16'h0;
    for (int g = 0; g < NGRP; g++) begin
      cnt = 4'h0;
      for (int c = 0; c < NCLS; c++) begin
        if (cls_grp[c] == 4'(g)) cnt = cnt + 4'h1;
      end
      if (pg_pfc_q[g] && cnt > 4'h1) viol = 1'b1;
    end
    for (int c = 0; c < NCLS; c++) begin
      if (!cls_grp[c][3]) sp_used[cls_grp[c]] = 1'b1;
    end
    if (dcb_mode && cha_mode && $countones(sp_used) > 1) viol = 1'b1;
  end

  // ==========================================================================
  // Arbitration
  sds_state_t st_q, st_d;
  logic [2:0] ptr_q, gcls_q;
  logic gmc_q, gvld_q, gdwrr_q;
  logic [7:0] mc_turn_q;
  logic signed [DEF_W-1:0] def_q [NCLS];
  logic signed [DEF_W-1:0] def_d [NCLS];

  // Multicast joins its unicast class as a second queue of equal rank
  wire [7:0] cls_ne = uc_queue_nempty | mc_queue_nempty;
  wire [7:0] sp_cand = is_sp & cls_ne;
  wire [7:0] rr_cand = ~is_sp & cls_ne;
  wire [3:0] sp_pick = sds_pick_sp(sp_cand, cls_rank);
  wire sp_hit = sp_pick[3];
  wire cur_elig = rr_cand[ptr_q] && def_q[ptr_q] > 0;
  wire [2:0] nxt_ptr = sds_next_rr(rr_cand, ptr_q);
  wire [2:0] sel_cls = sp_hit ? sp_pick[2:0] : ptr_q;
  wire dec = st_q == ST_IDLE && (sp_hit || cur_elig);
  wire both_ne = uc_queue_nempty[sel_cls] && mc_queue_nempty[sel_cls];
  wire sel_mc = both_ne ? mc_turn_q[sel_cls] : mc_queue_nempty[sel_cls];
  wire [7:0] w_nz = cls_wgt[nxt_ptr] == 8'h00 ? 8'h01 : cls_wgt[nxt_ptr];
  wire [DEF_W-1:0] quantum = DEF_W'(w_nz) << QUANTUM_SHIFT;
  wire [DEF_W-1:0] charge = DEF_W'(tx_frame_bytes);

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (dec) st_d = ST_BUSY;
        else if (|rr_cand && !sp_hit) st_d = ST_ADV;
      end
      ST_ADV: st_d = ST_IDLE;
      ST_BUSY: begin
        if (tx_frame_done) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Deficit: emptied queue forfeits credit, the next one gains its quantum
  always_comb begin
    for (int c = 0; c < NCLS; c++) begin
      def_d[c] = def_q[c];
      if (st_q == ST_ADV) begin
        if (3'(c) == ptr_q && !cls_ne[c]) def_d[c] = '0;
        if (3'(c) == nxt_ptr) def_d[c] = def_d[c] + $signed(quantum);
      end else if (st_q == ST_BUSY && tx_frame_done && gdwrr_q && 3'(c) == gcls_q) begin
        def_d[c] = def_q[c] - $signed(charge);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < NCLS; c++) def_q[c] <= '0;
    end else begin
      for (int c = 0; c < NCLS; c++) def_q[c] <= def_d[c];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      ptr_q <= 3'h7;
      gvld_q <= 1'b0;
      gcls_q <= 3'h0;
      gmc_q <= 1'b0;
      gdwrr_q <= 1'b0;
      mc_turn_q <= 8'h00;
    end else begin
      st_q <= st_d;
      if (st_q == ST_ADV) ptr_q <= nxt_ptr;
      if (dec) begin
        gvld_q <= 1'b1;
        gcls_q <= sel_cls;
        gmc_q <= sel_mc;
        gdwrr_q <= !sp_hit;
        if (both_ne) mc_turn_q[sel_cls] <= !sel_mc;
      end else if (st_q == ST_BUSY && tx_frame_done) begin
        gvld_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Status and outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pfc_en_q <= 8'h00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else begin
      for (int c = 0; c < NCLS; c++) pfc_en_q[c] <= pg_pfc_q[cls_grp[c]];
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_data;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
  wire [3:0] rd_grp = ra[5:2];
  wire [31:0] stat_w = {23'h0, err_q, 3'h0, gvld_q, gmc_q, gcls_q};
  wire [31:0] pg_rd = {23'h0, pg_pfc_q[rd_grp], pg_bw_q[rd_grp]};
  assign rd_hit = ra[11:6] == PG_REGION || ra == ADDR_CTRL || ra == ADDR_STAT ||
                  ra == ADDR_WGT_LO || ra == ADDR_WGT_HI || ra == ADDR_PRIO_MAP ||
                  ra == ADDR_PFC;
  assign rd_data = ra[11:6] == PG_REGION ? pg_rd
                 : ra == ADDR_CTRL ? {26'h0, ctrl_q}
                 : ra == ADDR_STAT ? stat_w
                 : ra == ADDR_WGT_LO ? wgt_q[31:0]
                 : ra == ADDR_WGT_HI ? wgt_q[63:32]
                 : ra == ADDR_PRIO_MAP ? prio_map_q
                 : ra == ADDR_PFC ? {24'h0, pfc_en_q}
                 : 32'h0;

  assign grant_valid = gvld_q;
  assign grant_class = gcls_q;
  assign grant_mc = gmc_q;
  assign class_pfc_en = pfc_en_q;
  assign map_error = err_q;

  // ==========================================================================
  // Checks
  // Rank compare kept apart from the picker, so a picker slip shows
  logic [7:0] sp_above;
  for (genvar c = 0; c < NCLS; c++) begin : g_sp_chk
    assign sp_above[c] = sp_cand[c] && cls_rank[4*c +: 4] > cls_rank[4*sel_cls +: 4];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_decide;
    dec && !sp_hit;
  endsequence
  sequence s_granted;
    ##1 gvld_q && gcls_q == $past(ptr_q);
  endsequence

  grant_nonempty_a: assert property (dec |-> cls_ne[sel_cls] &&
      (sel_mc ? mc_queue_nempty[sel_cls] : uc_queue_nempty[sel_cls]))
    else $error("grant to an empty queue");
  grant_hold_a: assert property (gvld_q && !(st_q == ST_BUSY && tx_frame_done)
      |=> gvld_q && $stable(gcls_q) && $stable(gmc_q))
    else $error("grant changed inside a frame");
  sp_first_a: assert property (st_q == ST_IDLE && |sp_cand |-> dec && is_sp[sel_cls])
    else $error("strict queue not served first");
  sp_top_a: assert property (dec && sp_hit |->
      sp_above == 8'h00 && sp_cand[sel_cls])
    else $error("strict pick not a strict candidate");
  rr_grant_a: assert property (s_decide |-> s_granted)
    else $error("rotation grant not at pointer");
  adv_once_a: assert property (st_q == ST_ADV |=> st_q == ST_IDLE && ptr_q == $past(nxt_ptr))
    else $error("pointer advance wrong");
  deficit_a: assert property (st_q == ST_BUSY && tx_frame_done && gdwrr_q
      |=> def_q[$past(gcls_q)] == $past(def_q[gcls_q]) - $signed($past(charge)))
    else $error("deficit not charged");
  restore_a: assert property (restore |=> pg_pfc_q == PG_PFC_RST && err_q
      && pg_bw_q[0] == PG_BW_RST)
    else $error("group table not restored");
  mc_rotate_a: assert property (dec && both_ne |=> mc_turn_q[$past(sel_cls)]
      != $past(mc_turn_q[sel_cls]))
    else $error("physical queue turn stuck");
  pfc_map_a: assert property (##1 $stable(prio_map_q) && $stable(pg_pfc_q)
      |-> class_pfc_en[0] == pg_pfc_q[cls_grp[0]])
    else $error("pfc enable does not follow group");
endmodule : sds_scheduler

// ### sds_far_end.sv
`timescale 1ns/10ps
module sds_far_end #(
  parameter int LEN_W = 14,
  parameter int FRAME_BYTES = 256
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic grant_valid,
  input wire logic [2:0] grant_class,
  input wire logic grant_mc,
  output logic [7:0] uc_queue_nempty,
  output logic [7:0] mc_queue_nempty,
  output logic tx_frame_done,
  output logic [LEN_W-1:0] tx_frame_bytes
);
  // ==========================================================================
  // Queue occupancy
  int uc_cnt [8];
  int mc_cnt [8];
  int seed = 49089;
  int hold_q;
  logic busy_q;
  // Load only while the MAC is idle, or a count update may be lost
  task automatic load(input int c, input bit m, input int n);
    if (m) begin
      mc_cnt[c] <= mc_cnt[c] + n;
    end else begin
      uc_cnt[c] <= uc_cnt[c] + n;
    end
  endtask : load
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      uc_queue_nempty[c] = (uc_cnt[c] > 0);
      mc_queue_nempty[c] = (mc_cnt[c] > 0);
    end
  end
  // ==========================================================================
  // Transmit MAC, random gap before each frame end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_frame_done <= 1'b0;
      tx_frame_bytes <= '0;
      busy_q <= 1'b0;
      hold_q <= 0;
    end else begin
      tx_frame_done <= 1'b0;
      tx_frame_bytes <= LEN_W'($random(seed));
      if (busy_q && hold_q == 0) begin
        tx_frame_done <= 1'b1;
        tx_frame_bytes <= LEN_W'(FRAME_BYTES);
        busy_q <= 1'b0;
        if (grant_mc) begin
          mc_cnt[grant_class] <= mc_cnt[grant_class] - 1;
        end else begin
          uc_cnt[grant_class] <= uc_cnt[grant_class] - 1;
        end
      end else if (busy_q) begin
        hold_q <= hold_q - 1;
      end else if (grant_valid && !tx_frame_done) begin
        busy_q <= 1'b1;
        hold_q <= {$random(seed)} % 4;
      end
    end
  end
endmodule : sds_far_end

// ### sds_scheduler_tb_top.sv
`timescale 1ns/10ps
module sds_scheduler_tb_top
  import sds_pkg::*;
;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} sds_note_t;
  logic clk, rst_b, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, fd, gv, gmc, merr, gv_q;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd_d;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  logic [7:0] uc, mc, pfc;
  logic [13:0] fb;
  logic [2:0] gc;
  sds_note_t rq[$], bq[$], gq[$];
  int fail_count, compares, cyc, cnt_tot, cnt[8];
  bit cnt_on;
  sds_scheduler #(.LEN_W(14)) uut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd_d), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .uc_queue_nempty(uc), .mc_queue_nempty(mc), .tx_frame_done(fd), .tx_frame_bytes(fb),
    .grant_valid(gv), .grant_class(gc), .grant_mc(gmc), .class_pfc_en(pfc),
    .map_error(merr));
  sds_far_end #(.LEN_W(14), .FRAME_BYTES(256)) far (.clk(clk), .rst_b(rst_b),
    .grant_valid(gv), .grant_class(gc), .grant_mc(gmc), .uc_queue_nempty(uc),
    .mc_queue_nempty(mc), .tx_frame_done(fd), .tx_frame_bytes(fb));
  // ==========================================================================
  // Checking
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (exp !== got) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  function automatic sds_note_t note(input logic [31:0] d, input logic [31:0] m,
                                     input logic [1:0] r);
    sds_note_t n;
    n.d = d;
    n.m = m;
    n.r = r;
    return n;
  endfunction : note
  // Monitor takes the oldest note for each read, write and grant result; while cnt_on it counts grants instead
  always @(posedge clk) begin
    sds_note_t n;
    gv_q <= gv;
    if (rv && rr) begin
      n = (rq.size() > 0) ? rq.pop_front() : note(32'hDEAD, 32'hFFFFFFFF, 2'h3);
      chk("rdata", n.d, rd_d & n.m);
      chk("rresp", 32'(n.r), 32'(rresp));
    end
    if (bv && br) begin
      n = (bq.size() > 0) ? bq.pop_front() : note(0, 0, 2'h3);
      chk("bresp", 32'(n.r), 32'(bresp));
    end
    if (gv && gv_q !== 1'b1 && cnt_on) begin
      if (cnt_tot < 16) cnt[gc]++;
      cnt_tot++;
    end else if (gv && gv_q !== 1'b1) begin
      n = (gq.size() > 0) ? gq.pop_front() : note(32'hBAD, 0, 0);
      chk("grant", n.d, {28'h0, gmc, gc});
    end
  end
  // ==========================================================================
  // Bus master
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    bq.push_back(note(0, 0, r));
    awa <= a;
    wd <= d;
    ws <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    @(posedge clk);
    rq.push_back(note(d & m, m, r));
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
  endtask : rd
  task automatic drain();
    // Loads land by non-blocking assignment, so let one edge pass first
    @(posedge clk);
    while (gq.size() != 0 || (uc | mc) != 8'h00) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask : drain
  task automatic exp_g(input bit m, input int c);
    gq.push_back(note({28'h0, m, 3'(c)}, 0, 0));
  endtask : exp_g
  // ==========================================================================
  // Clock, reset, timeout
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      end_sim();
    end
  end
  // ==========================================================================
  // Scenarios
  initial begin
    {rst_b, awv, wv, br, arv, rr} = '0;
    {awa, ara, wd, ws} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_CTRL, 0, 32'hFFFFFFFF, RESP_OKAY);
    rd(ADDR_WGT_LO, WGT_RST[31:0], 32'hFFFFFFFF, RESP_OKAY);
    rd(ADDR_PRIO_MAP, PRIO_MAP_RST, 32'hFFFFFFFF, RESP_OKAY);
    rd(ADDR_PFC, 32'h02, 32'hFFFFFFFF, RESP_OKAY);
    rd(12'h040, 32'h100, 32'hFFFFFFFF, RESP_OKAY);
    rd(12'h064, 32'h100, 32'hFFFFFFFF, RESP_OKAY);
    rd(12'h060, 0, 32'hFFFFFFFF, RESP_OKAY);
    rd(12'h0FC, 0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(ADDR_CTRL, 32'h8, RESP_OKAY);
    exp_g(0, 5); exp_g(0, 5); exp_g(0, 3); exp_g(0, 3);
    far.load(3, 0, 2); far.load(5, 0, 2);
    drain();
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    exp_g(0, 7); exp_g(0, 7); exp_g(0, 4);
    far.load(7, 0, 2); far.load(4, 0, 1);
    drain();
    wr(ADDR_CTRL, 32'h8, RESP_OKAY);
    exp_g(1, 6); exp_g(0, 5);
    far.load(6, 1, 1); far.load(5, 0, 1);
    drain();
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    wr(ADDR_WGT_LO, 32'h01010301, RESP_OKAY);
    cnt_on = 1'b1;
    far.load(0, 0, 10); far.load(1, 0, 20);
    drain();
    cnt_on = 1'b0;
    chk("share0", 32'h4, 32'(cnt[0]));
    chk("share1", 32'hC, 32'(cnt[1]));
    wr(ADDR_WGT_LO, WGT_RST[31:0], RESP_OKAY);
    wr(ADDR_PRIO_MAP, 32'h1EDC0A98, RESP_OKAY);
    wr(ADDR_CTRL, 32'h10, RESP_OKAY);
    rd(ADDR_PFC, 32'h0A, 32'hFFFFFFFF, RESP_OKAY);
    chk("class_pfc_en", 32'h0A, 32'(pfc));
    exp_g(0, 3); exp_g(0, 7); exp_g(0, 5);
    far.load(3, 0, 1); far.load(7, 0, 1); far.load(5, 0, 1);
    drain();
    wr(ADDR_CTRL, 32'h8, RESP_OKAY);
    exp_g(0, 2); exp_g(1, 2); exp_g(0, 2);
    far.load(2, 0, 2); far.load(2, 1, 1);
    drain();
    // Map still holds CoS3 on 15.0 and CoS7 on 15.1: two strict groups
    wr(ADDR_CTRL, 32'h30, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("map_error", 32'h1, 32'(merr));
    wr(ADDR_CTRL, 32'h8, RESP_OKAY);
    wr(ADDR_STAT, 32'h100, RESP_OKAY);
    chk("map_error", 32'h0, 32'(merr));
    wr(12'h060, 32'h33, RESP_OKAY);
    wr(ADDR_PRIO_MAP, 32'h1EDC0A99, RESP_OKAY);
    repeat (3) @(posedge clk);
    rd(ADDR_STAT, 32'h100, 32'h100, RESP_OKAY);
    rd(12'h060, 0, 32'hFFFFFFFF, RESP_OKAY);
    rd(12'h040, 32'h100, 32'hFFFFFFFF, RESP_OKAY);
    wr(ADDR_STAT, 32'h100, RESP_OKAY);
    rd(ADDR_STAT, 0, 32'h100, RESP_OKAY);
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule : sds_scheduler_tb_top
